/* hdl/ckcfg_pkg.sv */
// Purpose: Constants and types of the clock configuration and control registers.
// Assumes: APB slave, 32-bit data, one clock pclk at 50 MHz.
// Notes on behaviour
// R1: Bits 31:29 report power mode: run, to sleep, deep one, deep two, down.
// R2: Bits 23:22 give USB clock: 00 multiplier clock, 01 half of it.
// R3: Bits 15:11 give ref_clock as multiplier clock over (value+1) over two.
// R4: Bit 8 picks PLL input: 0 fast crystal, 1 fast internal RC.
// R5: Bits 2:0 pick clock output source; code 111 is reserved.
// R6: With bit 17 set, system runs from fast internal RC right after wakeup.
// R7: After such wakeup, switch back to chosen source once it is ready.
// R8: With monitor on, a stuck fast crystal moves system clock to internal RC.
// R9: Control bit 11 turns the fast internal RC oscillator off or on.
// R10: Clearing bit 11 is ignored while fast internal RC clocks the system.
// R11: Control bit 10 turns the fast crystal oscillator off or on.
// R12: Clearing bit 10 is refused while crystal clocks system or feeds PLL.
// R13: Clearing bit 9 is refused while the PLL clocks the system.
// R14: Control bits 2:0 select system clock; unknown codes mean fast internal RC.
// R15: Control bit 8 sets crystal drive gain low or high.
// R16: Crystal failure disables the crystal, and the PLL if it clocked system from the crystal.
// R17: Power mode field ignores writes; reserved bits read as zero.
package ckcfg_pkg;
   localparam logic [11:0] OFF_CFG       = 12'h000;
   localparam logic [11:0] OFF_CTL       = 12'h004;
   localparam logic [31:0] RST_CFG       = 32'h00000102;
   localparam logic [31:0] RST_CTL       = 32'h00000803;
   localparam logic [31:0] CFG_WMASK     = 32'h00C0F907;
   localparam logic [31:0] CTL_WMASK     = 32'h00030F07;
   localparam int          CFG_PMS_LSB   = 29;
   localparam int          CFG_USB_LSB   = 22;
   localparam int          CFG_REF_LSB   = 11;
   localparam int          CFG_PSRC_BIT  = 8;
   localparam int          CFG_CKO_LSB   = 0;
   localparam int          CTL_WAKE_BIT  = 17;
   localparam int          CTL_MON_BIT   = 16;
   localparam int          CTL_IRC_BIT   = 11;
   localparam int          CTL_XTAL_BIT  = 10;
   localparam int          CTL_PLL_BIT   = 9;
   localparam int          CTL_GAIN_BIT  = 8;
   localparam int          CTL_SW_LSB    = 0;
   localparam logic [2:0]  SW_IRC        = 3'h3;
   localparam logic [2:0]  PMS_RST       = 3'h0;
   localparam int          CLK_MHZ       = 50;
   localparam int          STUCK_TIME_NS = 1000;
   localparam int          STUCK_CYCLES  = (STUCK_TIME_NS * CLK_MHZ) / 1000;
   localparam int          SYNC_W        = 6;

   typedef enum logic [2:0] {
      SRC_PLL, SRC_XTAL, SRC_IRC, SRC_SXTAL, SRC_SIRC
   } ckcfg_src_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ckcfg_apb_req_t;

   typedef struct packed {
      logic pll;
      logic xtal;
      logic irc;
      logic sxtal;
      logic sirc;
   } ckcfg_ready_t;
endpackage

/* hdl/ckcfg_regs.sv */
// Purpose: Clock configuration and control registers with source switching.
// Assumes: APB on pclk; ready flags and crystal level come from pins.
// Notes: Zero-wait APB slave; unmapped addresses answer with pslverr.
`timescale 1ns/1ps
`default_nettype none
module ckcfg_regs #(
   parameter int STUCK_LIMIT = ckcfg_pkg::STUCK_CYCLES
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire ckcfg_pkg::ckcfg_apb_req_t apb,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic [2:0]               power_mode_in,
   input  wire logic                     wakeup_event,
   input  wire ckcfg_pkg::ckcfg_ready_t  ready_pins,
   input  wire logic                     fast_crystal_level,
   output ckcfg_pkg::ckcfg_src_t         sys_source,
   output logic                          pll_input_select,
   output logic [1:0]                    usb_divisor,
   output logic [6:0]                    ref_divisor,
   output logic [2:0]                    clock_out_select,
   output logic                          fast_internal_osc_on,
   output logic                          fast_crystal_osc_on,
   output logic                          multiplier_loop_on,
   output logic                          crystal_drive_gain,
   output logic                          crystal_fail
);
   import ckcfg_pkg::*;

   initial begin
      if (STUCK_LIMIT < 2) $error("ckcfg_regs: STUCK_LIMIT too small.");
   end

   ////////////////////////////////////////////////////////////////////////
   // Helpers.

   function automatic ckcfg_src_t src_of(input logic [2:0] code);
      ckcfg_src_t s;
      s = SRC_IRC;
      unique casez (code)
         3'b00?:  s = SRC_PLL;
         3'b010:  s = SRC_XTAL;
         3'b011:  s = SRC_IRC;
         3'b110:  s = SRC_SXTAL;
         3'b111:  s = SRC_SIRC;
         default: s = SRC_IRC;
      endcase
      return s;
   endfunction

   function automatic logic rdy_of(input ckcfg_src_t s,
                                   input ckcfg_ready_t r);
      logic v;
      v = 1'b0;
      unique case (s)
         SRC_PLL:   v = r.pll;
         SRC_XTAL:  v = r.xtal;
         SRC_IRC:   v = r.irc;
         SRC_SXTAL: v = r.sxtal;
         SRC_SIRC:  v = r.sirc;
      endcase
      return v;
   endfunction

   function automatic logic [6:0] ref_div_of(input logic [4:0] f);
      return {6'({1'b0, f} + 6'h01), 1'b0};
   endfunction

   function automatic logic [1:0] usb_div_of(input logic [1:0] f);
      return (f == 2'h1) ? 2'h2 : 2'h1;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and crystal monitor.

   logic [SYNC_W-1:0] sync_level;
   ckcfg_ready_t      rdy;
   logic              xtal_level;
   logic              stuck;

   ckcfg_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     ({ready_pins, fast_crystal_level}),
      .level   (sync_level)
   );

   assign rdy        = sync_level[SYNC_W-1:1];
   assign xtal_level = sync_level[0];

   logic [31:0] cfg_reg;
   logic [31:0] ctl_reg;
   logic [2:0]  pms;
   logic        mon_en;
   logic        wake_en;
   logic [2:0]  sw_code;
   logic        psrc;

   assign mon_en  = ctl_reg[CTL_MON_BIT];
   assign wake_en = ctl_reg[CTL_WAKE_BIT];
   assign sw_code = ctl_reg[CTL_SW_LSB +: 3];
   assign psrc    = cfg_reg[CFG_PSRC_BIT];

   ckcfg_stuck #(
      .LIMIT (STUCK_LIMIT)
   ) u_stuck (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (mon_en),
      .level   (xtal_level),
      .stuck   (stuck)
   );

   ////////////////////////////////////////////////////////////////////////
   // APB decode.

   logic setup;
   logic wr;
   logic hit_cfg;
   logic hit_ctl;
   logic fail;
   logic xtal_sys;
   logic pll_on_xtal;

   assign setup   = apb.psel && !apb.penable;
   assign wr      = apb.psel && apb.penable && pready && apb.pwrite;
   assign hit_cfg = apb.paddr == OFF_CFG;
   assign hit_ctl = apb.paddr == OFF_CTL;

   // Hardware events that act on the control register.
   assign fail        = mon_en && stuck;
   assign pll_on_xtal = sys_source == SRC_PLL && !psrc;
   assign xtal_sys    = sys_source == SRC_XTAL || pll_on_xtal;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= setup;
         pslverr <= setup && !(hit_cfg || hit_ctl);
         prdata  <= 32'h00000000;
         if (setup && !apb.pwrite && hit_cfg) begin
            prdata <= cfg_reg; // R17
         end else if (setup && !apb.pwrite && hit_ctl) begin
            prdata <= ctl_reg; // R17
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration register.

   logic [31:0] next_cfg;

   always_comb begin
      next_cfg = cfg_reg;
      if (wr && hit_cfg) begin
         next_cfg = apb.pwdata & CFG_WMASK; // R2 R3 R4 R5 R17
      end
      next_cfg[CFG_PMS_LSB +: 3] = pms; // R1
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pms <= PMS_RST;
      end else begin
         pms <= power_mode_in; // R1
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= RST_CFG;
      end else begin
         cfg_reg <= next_cfg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register with refused clears and failure handling.

   logic [31:0] next_ctl;

   always_comb begin
      next_ctl = ctl_reg;
      if (wr && hit_ctl) begin
         next_ctl = apb.pwdata & CTL_WMASK; // R9 R11 R14 R15
         if (sys_source == SRC_IRC) begin
            next_ctl[CTL_IRC_BIT] = 1'b1; // R10
         end
         if (ctl_reg[CTL_XTAL_BIT] &&
             (sys_source == SRC_XTAL ||
              (!psrc && ctl_reg[CTL_PLL_BIT]))) begin
            next_ctl[CTL_XTAL_BIT] = 1'b1; // R12
         end
         if (ctl_reg[CTL_PLL_BIT] && sys_source == SRC_PLL) begin
            next_ctl[CTL_PLL_BIT] = 1'b1; // R13
         end
      end
      if (fail) begin
         next_ctl[CTL_XTAL_BIT] = 1'b0; // R16
         if (pll_on_xtal) begin
            next_ctl[CTL_PLL_BIT] = 1'b0; // R16
         end
         if (xtal_sys) begin
            next_ctl[CTL_SW_LSB +: 3] = SW_IRC; // R8
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_reg <= RST_CTL;
      end else begin
         ctl_reg <= next_ctl;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // System clock source tracking.

   ckcfg_src_t sel_src;
   logic       sel_rdy;
   logic       wake_hold;

   assign sel_src = src_of(sw_code); // R14
   assign sel_rdy = rdy_of(sel_src, rdy);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_source <= SRC_IRC;
         wake_hold  <= 1'b0;
      end else if (fail && xtal_sys) begin
         sys_source <= SRC_IRC; // R8
         wake_hold  <= 1'b0;
      end else if (wakeup_event && wake_en) begin
         sys_source <= SRC_IRC; // R6
         wake_hold  <= 1'b1;
      end else if (sel_src != sys_source && sel_rdy) begin
         sys_source <= sel_src; // R7 R14
         wake_hold  <= 1'b0;
      end else if (sel_rdy) begin
         wake_hold  <= 1'b0; // R7
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crystal_fail <= 1'b0;
      end else begin
         crystal_fail <= fail; // R8
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Divider settings for the downstream clock generators.

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_divisor <= ref_div_of(RST_CFG[CFG_REF_LSB +: 5]);
         usb_divisor <= usb_div_of(RST_CFG[CFG_USB_LSB +: 2]);
      end else begin
         ref_divisor <= ref_div_of(cfg_reg[CFG_REF_LSB +: 5]); // R3
         usb_divisor <= usb_div_of(cfg_reg[CFG_USB_LSB +: 2]); // R2
      end
   end

   assign pll_input_select     = psrc;                             // R4
   assign clock_out_select     = cfg_reg[CFG_CKO_LSB +: 3];        // R5
   assign fast_internal_osc_on = ctl_reg[CTL_IRC_BIT];             // R9
   assign fast_crystal_osc_on  = ctl_reg[CTL_XTAL_BIT];            // R11
   assign multiplier_loop_on   = ctl_reg[CTL_PLL_BIT];
   assign crystal_drive_gain   = ctl_reg[CTL_GAIN_BIT];            // R15

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_PMS_TRACK: assert property ( // R1
      ##2 cfg_reg[CFG_PMS_LSB +: 3] == $past(power_mode_in, 2))
      else $error("Power mode field does not follow its input.");

   AST_USB_DIV: assert property ( // R2
      ##1 usb_divisor == usb_div_of($past(cfg_reg[CFG_USB_LSB +: 2])))
      else $error("USB divisor wrong.");

   AST_REF_DIV: assert property ( // R3
      ##1 ref_divisor == ref_div_of($past(cfg_reg[CFG_REF_LSB +: 5])))
      else $error("Reference divisor wrong.");

   AST_PLL_SRC: assert property ( // R4
      wr && hit_cfg |=> pll_input_select == $past(apb.pwdata[CFG_PSRC_BIT]))
      else $error("PLL input select not written.");

   AST_CKO_SEL: assert property ( // R5
      wr && hit_cfg |=> clock_out_select == $past(apb.pwdata[2:0]))
      else $error("Clock output select not written.");

   AST_WAKE_IRC: assert property ( // R6
      wakeup_event && wake_en && !fail |=> sys_source == SRC_IRC && wake_hold)
      else $error("Wakeup did not run from internal RC.");

   AST_WAKE_BACK: assert property ( // R7
      wake_hold && sel_rdy && !fail && !wakeup_event
      |=> sys_source == $past(sel_src) && !wake_hold)
      else $error("No return to selected source after wakeup.");

   AST_FAIL_IRC: assert property ( // R8
      fail && xtal_sys |=> sys_source == SRC_IRC ##1 sw_code == SW_IRC)
      else $error("Crystal failure did not move clock to internal RC.");

   AST_IRC_KEEP: assert property ( // R10
      sys_source == SRC_IRC && fast_internal_osc_on |=> fast_internal_osc_on)
      else $error("Internal RC disabled while in use.");

   AST_XTAL_KEEP: assert property ( // R12
      sys_source == SRC_XTAL && fast_crystal_osc_on && !fail
      |=> fast_crystal_osc_on)
      else $error("Crystal disabled while in use.");

   AST_PLL_KEEP: assert property ( // R13
      sys_source == SRC_PLL && multiplier_loop_on && !fail
      |=> multiplier_loop_on)
      else $error("PLL disabled while clocking the system.");

   AST_FAIL_OFF: assert property ( // R16
      fail && pll_on_xtal |=> !fast_crystal_osc_on && !multiplier_loop_on)
      else $error("Crystal failure left oscillator or PLL on.");

   AST_RSV_ZERO: assert property ( // R17
      setup && !apb.pwrite && hit_ctl |=> (prdata & ~CTL_WMASK) == 32'h00000000)
      else $error("Reserved control bits read nonzero.");

endmodule // ckcfg_regs
`default_nettype wire

/* hdl/ckcfg_stuck.sv */
// Purpose: Detects a fast crystal clock stuck at low or high.
// Assumes: Input is already synchronised to pclk.
// Notes: One pulse per stuck episode while enabled.
`timescale 1ns/1ps
`default_nettype none
module ckcfg_stuck #(
   parameter int LIMIT = 50
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic enable,
   input  wire logic level,
   output logic      stuck
);
   logic [15:0] count;
   logic        prev;
   logic        fired;
   initial begin
      if (LIMIT < 2 || LIMIT > 65535) $error("ckcfg_stuck: LIMIT out of range.");
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev  <= 1'b0;
         count <= 16'h0000;
         fired <= 1'b0;
         stuck <= 1'b0;
      end else begin
         prev  <= level;
         stuck <= 1'b0;
         if (!enable || level != prev) begin
            count <= 16'h0000;
            fired <= 1'b0;
         end else if (count == 16'(LIMIT - 1)) begin
            stuck <= !fired;
            fired <= 1'b1;
         end else begin
            count <= count + 16'h0001;
         end
      end
   end
endmodule // ckcfg_stuck
`default_nettype wire

/* hdl/ckcfg_sync.sv */
// Purpose: Two-flop synchroniser for pins from outside the pclk domain.
// Assumes: Each bit is an independent level.
// Notes: Only the second stage may be read.
`timescale 1ns/1ps
`default_nettype none
module ckcfg_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] level
);
   logic [WIDTH-1:0] stage1;
   initial begin
      if (WIDTH < 1) $error("ckcfg_sync: WIDTH must be at least one.");
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= '0;
         level  <= '0;
      end else begin
         stage1 <= pin;
         level  <= stage1;
      end
   end
endmodule // ckcfg_sync
`default_nettype wire

/* verification/clock_config_control_regs_tb.sv */
// Purpose: Self-checking bench of the clock configuration and control registers.
// Assumes: Zero-wait APB slave, all ready pins high unless a scenario drops one.
// Notes: A register model in the bench predicts every read and every output except crystal_fail and the APB responses.
`timescale 1ns/1ps
`default_nettype none
module clock_config_control_regs_tb;
   import ckcfg_pkg::*;
   logic           pclk;
   logic           presetn;
   ckcfg_apb_req_t apb;
   logic [31:0]    prdata;
   logic           pready;
   logic           pslverr;
   logic [2:0]     power_mode_in;
   logic           wakeup_event;
   ckcfg_ready_t   ready_pins;
   logic           fast_crystal_level;
   ckcfg_src_t     sys_source;
   logic           pll_input_select;
   logic [1:0]     usb_divisor;
   logic [6:0]     ref_divisor;
   logic [2:0]     clock_out_select;
   logic           fast_internal_osc_on;
   logic           fast_crystal_osc_on;
   logic           multiplier_loop_on;
   logic           crystal_drive_gain;
   logic           crystal_fail;
   logic           run_xtal;
   logic [31:0]    mcfg;
   logic [31:0]    mctl;
   logic [2:0]     mpm;
   ckcfg_src_t     msys;
   logic [31:0]    seed;
   int             errors;
   int             compares;
   int             cycles;

   ckcfg_regs #(.STUCK_LIMIT(4)) dut (
      .pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .power_mode_in(power_mode_in), .wakeup_event(wakeup_event),
      .ready_pins(ready_pins), .fast_crystal_level(fast_crystal_level), .sys_source(sys_source),
      .pll_input_select(pll_input_select), .usb_divisor(usb_divisor), .ref_divisor(ref_divisor),
      .clock_out_select(clock_out_select), .fast_internal_osc_on(fast_internal_osc_on),
      .fast_crystal_osc_on(fast_crystal_osc_on), .multiplier_loop_on(multiplier_loop_on),
      .crystal_drive_gain(crystal_drive_gain), .crystal_fail(crystal_fail)
   );

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // A running crystal toggles every cycle; stopping it makes the stuck case.
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (run_xtal) fast_crystal_level <= ~fast_crystal_level;
      if (cycles == 20000) begin
         errors++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   function automatic ckcfg_src_t dec(input logic [2:0] c);
      case (c)
         3'h0, 3'h1: return SRC_PLL;
         3'h2:       return SRC_XTAL;
         3'h6:       return SRC_SXTAL;
         3'h7:       return SRC_SIRC;
         default:    return SRC_IRC;
      endcase
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_src(input ckcfg_src_t e);
      compares++;
      if (sys_source !== e) begin
         errors++;
         $display("mismatch at %0t: source got %h expected %h", $time, sys_source, e);
      end
   endtask

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      apb.penable <= 1'b1;
      @(posedge pclk);
      // Only pready or the bench timeout ends this wait.
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      apb <= '0;
   endtask

   task automatic wr_ctl(input logic [31:0] d);
      logic [31:0] n;
      logic [31:0] q;
      logic        e;
      n = d & CTL_WMASK;
      if (mctl[CTL_IRC_BIT] && msys == SRC_IRC) n[CTL_IRC_BIT] = 1'b1;
      if (mctl[CTL_XTAL_BIT] && (msys == SRC_XTAL || (mctl[CTL_PLL_BIT] && !mcfg[CFG_PSRC_BIT])))
         n[CTL_XTAL_BIT] = 1'b1;
      if (mctl[CTL_PLL_BIT] && msys == SRC_PLL) n[CTL_PLL_BIT] = 1'b1;
      xfer(1'b1, OFF_CTL, d, q, e);
      mctl = n;
      msys = dec(n[2:0]);
      repeat (6) @(posedge pclk);
   endtask

   task automatic check_all();
      logic [31:0] q;
      logic        e;
      xfer(1'b0, OFF_CFG, 32'h0, q, e);
      chk(q, mcfg | {mpm, 29'h0});
      xfer(1'b0, OFF_CTL, 32'h0, q, e);
      chk(q, mctl);
      chk({31'h0, pll_input_select}, {31'h0, mcfg[8]});
      chk({30'h0, usb_divisor}, (mcfg[23:22] == 2'h1) ? 32'h2 : 32'h1);
      chk({25'h0, ref_divisor}, ({27'h0, mcfg[15:11]} + 32'h1) * 32'h2);
      chk({29'h0, clock_out_select}, {29'h0, mcfg[2:0]});
      chk({28'h0, fast_internal_osc_on, fast_crystal_osc_on, multiplier_loop_on, crystal_drive_gain},
          {28'h0, mctl[11:8]});
      chk_src(msys);
   endtask

   task automatic end_sim();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] q;
      logic        e;
      int          n;
      presetn = 1'b0;
      apb = '0;
      power_mode_in = 3'h0;
      wakeup_event = 1'b0;
      ready_pins = '1;
      fast_crystal_level = 1'b0;
      run_xtal = 1'b1;
      errors = 0;
      compares = 0;
      cycles = 0;
      seed = 32'he7f6;
      mcfg = RST_CFG;
      mctl = RST_CTL;
      mpm = PMS_RST;
      msys = SRC_IRC;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      check_all();
      xfer(1'b0, 12'h008, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      xfer(1'b1, 12'h00C, 32'hFFFFFFFF, q, e);
      chk({31'h0, e}, 32'h1);
      for (int i = 0; i < 12; i++) begin
         seed = xs(seed);
         q = seed;
         q[2:0] = 3'(i);
         q[23:22] = 2'(i);
         mcfg = q & CFG_WMASK;
         // The power mode needs two edges to reach the register, so it leads the write.
         mpm = 3'(i % 5);
         power_mode_in <= mpm;
         xfer(1'b1, OFF_CFG, q, q, e);
         check_all();
      end
      for (int c = 0; c < 8; c++) begin
         wr_ctl(32'h00000F00 | 32'(c));
         check_all();
      end
      wr_ctl(32'h00000803);
      wr_ctl(32'h00000003);
      check_all();
      wr_ctl(32'h00000A00);
      wr_ctl(32'h00000800);
      check_all();
      wr_ctl(32'h00000C02);
      wr_ctl(32'h00000802);
      check_all();
      wr_ctl(32'h00020C02);
      ready_pins.xtal <= 1'b0;
      repeat (4) @(posedge pclk);
      wakeup_event <= 1'b1;
      @(posedge pclk);
      wakeup_event <= 1'b0;
      repeat (2) @(posedge pclk);
      chk_src(SRC_IRC);
      repeat (4) @(posedge pclk);
      chk_src(SRC_IRC);
      ready_pins.xtal <= 1'b1;
      n = 0;
      while (sys_source !== SRC_XTAL && n < 10) begin
         @(posedge pclk);
         n++;
      end
      chk_src(SRC_XTAL);
      mcfg = mcfg & ~32'h00000100;
      xfer(1'b1, OFF_CFG, mcfg, q, e);
      wr_ctl(32'h00010E00);
      check_all();
      run_xtal <= 1'b0;
      n = 0;
      while (crystal_fail !== 1'b1 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, crystal_fail}, 32'h1);
      @(posedge pclk);
      chk({31'h0, crystal_fail}, 32'h0);
      mctl = 32'h00010803;
      msys = SRC_IRC;
      check_all();
      run_xtal <= 1'b1;
      wr_ctl(32'h00000803);
      check_all();
      end_sim();
   end
endmodule // clock_config_control_regs_tb
`default_nettype wire
